// >>> design/nco_defs.vh
// register map, field positions and reset values of the numeric oscillator
`ifndef NCO_DEFS_VH
`define NCO_DEFS_VH

// ----------------------------------------------------------------------
// register byte addresses (one aligned 32-bit word each)
// ----------------------------------------------------------------------
`define NCO_ADDR_ACC_LOW 12'h000
`define NCO_ADDR_ACC_HIGH 12'h004
`define NCO_ADDR_ACC_UPPER 12'h008
`define NCO_ADDR_INC_LOW 12'h00C
`define NCO_ADDR_INC_HIGH 12'h010
`define NCO_ADDR_INC_UPPER 12'h014
`define NCO_ADDR_CONTROL 12'h018
`define NCO_ADDR_CLOCK 12'h01C
`define NCO_ADDR_IRQ 12'h020

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define NCO_CTL_ENABLE 7
`define NCO_CTL_OUTPUT 5
`define NCO_CTL_INVERT 4
`define NCO_CTL_PULSE 0
`define NCO_IRQ_FLAG 0
`define NCO_IRQ_ENABLE 1
`define NCO_IRQ_PERIPH 2
`define NCO_IRQ_GLOBAL 3

// ----------------------------------------------------------------------
// reset values and widths
// ----------------------------------------------------------------------
`define NCO_RESET_BYTE 8'h00
`define NCO_ACC_WIDTH 20
`define NCO_SRC_COUNT 16
`define NCO_SRC_FAST_OSC 4'h1
`define NCO_SRC_RESERVED 4'hF

`endif

// >>> design/nco_core.v
// numeric oscillator: accumulator, increment shadow, output stage, apb regs
//
// Behaviour
// - 20-bit accumulator readable/writable as three bytes
// - each input clock edge adds shadow increment
// - adder carry is the raw overflow
// - 20-bit increment held in three byte registers
// - enabled: low-byte write loads shadow two edges later
// - disabled: increment writes copy to shadow one clock later
// - shadow increment never visible to software
// - fixed duty mode toggles output per overflow
// - pulse select bit picks pulse or fixed duty
// - pulse asserts after overflow, lasts 1 to 128
// - pulse longer than interval gives no toggling
// - final stage applies output invert bit
// - invert change with irq enabled raises interrupt
// - every overflow sets the overflow flag
// - request needs enable, irq, peripheral, global enables
// - any reset clears all registers to zero
// - keeps running independent of system sleep
// - fast oscillator kept alive in sleep when selected and enabled
// - clock source select picks accumulator clock
// - final output routed to other peripherals
// - pulse width field is power of two periods
// - read-only status bit shows output level
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
`include "nco_defs.vh"

module nco_core #(
   parameter ACC_WIDTH = `NCO_ACC_WIDTH,
   parameter SRC_COUNT = `NCO_SRC_COUNT
) (
   input wire i_clock,
   input wire i_sys_rst,
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [11:0] i_paddr,
   input wire [31:0] i_pwdata,
   output wire o_pready,
   output wire o_pslverr,
   output reg [31:0] o_prdata,
   input wire [SRC_COUNT-1:0] i_clock_sources,
   input wire i_sleep,
   output wire o_oscillator_output,
   output wire o_overflow_irq,
   output wire o_fast_osc_keep_on,
   output wire o_raw_carry_out
);

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   reg [ACC_WIDTH-1:0] acc_reg;
   reg [ACC_WIDTH-1:0] inc_reg;
   reg [ACC_WIDTH-1:0] shadow_reg;
   reg enable_reg;
   reg invert_reg;
   reg pulse_reg;
   reg [2:0] width_reg;
   reg [3:0] source_reg;
   reg flag_reg;
   reg irq_en_reg;
   reg periph_en_reg;
   reg global_en_reg;
   reg out_reg;
   reg [7:0] pulse_cnt_reg;
   reg [1:0] load_pend_reg;
   reg [SRC_COUNT-1:0] src_sync1_reg;
   reg [SRC_COUNT-1:0] src_sync2_reg;
   reg src_prev_reg;
   reg final_prev_reg;

   wire bus_write;
   wire [ACC_WIDTH:0] sum;
   wire clk_sel;
   wire tick;
   wire carry;
   wire [7:0] width_cycles;
   wire final_out;
   wire inc_low_write;
   wire inc_any_write;

   // apb answers in the access phase with no wait states
   assign o_pready = 1'b1;
   assign o_pslverr = 1'b0;
   assign bus_write = i_psel & i_penable & i_pwrite;

   // ----------------------------------------------------------------------
   // oscillator clock selection
   // ----------------------------------------------------------------------
   // every source is an outside level: two flops before anything looks
   always @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         src_sync1_reg <= {SRC_COUNT{1'b0}};
         src_sync2_reg <= {SRC_COUNT{1'b0}};
         src_prev_reg <= 1'b0;
      end else begin
         src_sync1_reg <= i_clock_sources;
         src_sync2_reg <= src_sync1_reg;
         src_prev_reg <= clk_sel;
      end
   end

   // reserved code selects no clock at all
   assign clk_sel = (source_reg == `NCO_SRC_RESERVED) ? 1'b0 :
      src_sync2_reg[source_reg];
   // rising edge of the chosen source is a one-cycle enable
   assign tick = clk_sel & ~src_prev_reg & enable_reg;

   // sleep gates only the keep-on request, which also needs enable and the fast source
   assign o_fast_osc_keep_on = enable_reg &
      (source_reg == `NCO_SRC_FAST_OSC) & i_sleep;

   // ----------------------------------------------------------------------
   // adder and accumulator
   // ----------------------------------------------------------------------
   assign sum = {1'b0, acc_reg} + {1'b0, shadow_reg};
   assign carry = tick & sum[ACC_WIDTH];
   assign o_raw_carry_out = carry;

   assign inc_low_write = bus_write &&
      (i_paddr == `NCO_ADDR_INC_LOW);
   assign inc_any_write = inc_low_write || (bus_write &&
      ((i_paddr == `NCO_ADDR_INC_HIGH) ||
      (i_paddr == `NCO_ADDR_INC_UPPER)));

   // accumulator: bus writes are undefined while running; bus wins
   always @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         acc_reg <= {ACC_WIDTH{1'b0}};
      end else if (bus_write && i_paddr == `NCO_ADDR_ACC_LOW) begin
         acc_reg[7:0] <= i_pwdata[7:0];
      end else if (bus_write && i_paddr == `NCO_ADDR_ACC_HIGH) begin
         acc_reg[15:8] <= i_pwdata[7:0];
      end else if (bus_write && i_paddr == `NCO_ADDR_ACC_UPPER) begin
         acc_reg[ACC_WIDTH-1:16] <= i_pwdata[ACC_WIDTH-17:0];
      end else if (tick) begin
         acc_reg <= sum[ACC_WIDTH-1:0];
      end
   end

   // ----------------------------------------------------------------------
   // increment registers and shadow
   // ----------------------------------------------------------------------
   // load_pend counts oscillator edges after a low-byte write
   always @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         inc_reg <= {ACC_WIDTH{1'b0}};
         shadow_reg <= {ACC_WIDTH{1'b0}};
         load_pend_reg <= 2'b00;
      end else begin
         if (bus_write && i_paddr == `NCO_ADDR_INC_LOW) begin
            inc_reg[7:0] <= i_pwdata[7:0];
         end
         if (bus_write && i_paddr == `NCO_ADDR_INC_HIGH) begin
            inc_reg[15:8] <= i_pwdata[7:0];
         end
         if (bus_write && i_paddr == `NCO_ADDR_INC_UPPER) begin
            inc_reg[ACC_WIDTH-1:16] <= i_pwdata[ACC_WIDTH-17:0];
         end
         if (!enable_reg) begin
            // copy one cycle after the write, from the stored bytes
            load_pend_reg <= {1'b0, inc_any_write};
            if (load_pend_reg[0]) begin
               shadow_reg <= inc_reg;
            end
         end else if (inc_low_write) begin
            load_pend_reg <= 2'b10;
         end else if (tick && load_pend_reg == 2'b10) begin
            load_pend_reg <= 2'b01;
         end else if (tick && load_pend_reg == 2'b01) begin
            shadow_reg <= inc_reg;
            load_pend_reg <= 2'b00;
         end
      end
   end

   // ----------------------------------------------------------------------
   // output stage
   // ----------------------------------------------------------------------
   assign width_cycles = 8'h01 << width_reg;

   // pulse count restarts on overflow so short intervals never release
   always @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         out_reg <= 1'b0;
         pulse_cnt_reg <= 8'h00;
      end else if (!enable_reg) begin
         out_reg <= 1'b0;
         pulse_cnt_reg <= 8'h00;
      end else if (!pulse_reg) begin
         pulse_cnt_reg <= 8'h00;
         if (carry) begin
            out_reg <= ~out_reg;
         end
      end else if (carry) begin
         out_reg <= 1'b1;
         pulse_cnt_reg <= width_cycles;
      end else if (tick && pulse_cnt_reg != 8'h00) begin
         pulse_cnt_reg <= pulse_cnt_reg - 8'h01;
         if (pulse_cnt_reg == 8'h01) begin
            out_reg <= 1'b0;
         end
      end
   end

   assign final_out = out_reg ^ invert_reg;
   assign o_oscillator_output = final_out;

   // ----------------------------------------------------------------------
   // control and interrupt registers
   // ----------------------------------------------------------------------
   // set beats a software clear in the same cycle
   always @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         enable_reg <= 1'b0;
         invert_reg <= 1'b0;
         pulse_reg <= 1'b0;
         width_reg <= 3'b000;
         source_reg <= 4'h0;
         flag_reg <= 1'b0;
         irq_en_reg <= 1'b0;
         periph_en_reg <= 1'b0;
         global_en_reg <= 1'b0;
         final_prev_reg <= 1'b0;
      end else begin
         final_prev_reg <= final_out;
         if (bus_write && i_paddr == `NCO_ADDR_CONTROL) begin
            enable_reg <= i_pwdata[`NCO_CTL_ENABLE];
            invert_reg <= i_pwdata[`NCO_CTL_INVERT];
            pulse_reg <= i_pwdata[`NCO_CTL_PULSE];
         end
         if (bus_write && i_paddr == `NCO_ADDR_CLOCK) begin
            width_reg <= i_pwdata[7:5];
            source_reg <= i_pwdata[3:0];
         end
         if (bus_write && i_paddr == `NCO_ADDR_IRQ) begin
            irq_en_reg <= i_pwdata[`NCO_IRQ_ENABLE];
            periph_en_reg <= i_pwdata[`NCO_IRQ_PERIPH];
            global_en_reg <= i_pwdata[`NCO_IRQ_GLOBAL];
         end
         if (carry) begin
            flag_reg <= 1'b1;
         end else if (irq_en_reg && enable_reg &&
               final_out != final_prev_reg &&
               invert_reg != (out_reg ^ final_prev_reg)) begin
            flag_reg <= 1'b1;
         end else if (bus_write && i_paddr == `NCO_ADDR_IRQ &&
               !i_pwdata[`NCO_IRQ_FLAG]) begin
            flag_reg <= 1'b0;
         end
      end
   end

   assign o_overflow_irq = flag_reg & enable_reg & irq_en_reg &
      periph_en_reg & global_en_reg;

   // ----------------------------------------------------------------------
   // read data; shadow has no address
   // ----------------------------------------------------------------------
   always @* begin
      o_prdata = 32'h00000000;
      case (i_paddr)
         `NCO_ADDR_ACC_LOW: o_prdata[7:0] = acc_reg[7:0];
         `NCO_ADDR_ACC_HIGH: o_prdata[7:0] = acc_reg[15:8];
         `NCO_ADDR_ACC_UPPER: o_prdata[ACC_WIDTH-17:0] =
            acc_reg[ACC_WIDTH-1:16];
         `NCO_ADDR_INC_LOW: o_prdata[7:0] = inc_reg[7:0];
         `NCO_ADDR_INC_HIGH: o_prdata[7:0] = inc_reg[15:8];
         `NCO_ADDR_INC_UPPER: o_prdata[ACC_WIDTH-17:0] =
            inc_reg[ACC_WIDTH-1:16];
         `NCO_ADDR_CONTROL: o_prdata[7:0] = {enable_reg, 1'b0,
            final_out, invert_reg, 3'b000, pulse_reg};
         `NCO_ADDR_CLOCK: o_prdata[7:0] = {width_reg, 1'b0, source_reg};
         `NCO_ADDR_IRQ: o_prdata[7:0] = {4'h0, global_en_reg,
            periph_en_reg, irq_en_reg, flag_reg};
         default: o_prdata = 32'h00000000;
      endcase
   end

endmodule

// >>> bench/nco_props.sv
// port checker for the numeric oscillator, bound to the core
`timescale 1ns/1ps
`include "nco_defs.vh"
module nco_props (
   input wire i_clock,
   input wire i_sys_rst,
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [11:0] i_paddr,
   input wire o_pready,
   input wire o_pslverr,
   input wire [31:0] o_prdata,
   input wire i_sleep,
   input wire o_oscillator_output,
   input wire o_overflow_irq,
   input wire o_fast_osc_keep_on,
   input wire o_raw_carry_out
);
   // write strobe at the completing access edge
   wire wr = i_psel && i_penable && i_pwrite;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   // ----------------------------------------------------------------------
   // bus and flag relations
   // ----------------------------------------------------------------------
   a_ready_high: assert property (o_pready && !o_pslverr)
      else $error("bus answer not zero wait");
   a_unmapped_zero: assert property
      ((i_psel && i_paddr > `NCO_ADDR_IRQ) |-> o_prdata == 32'h0)
      else $error("unmapped read not zero");
   a_carry_gap: assert property (o_raw_carry_out |=> !o_raw_carry_out)
      else $error("carry longer than one cycle");
   a_keep_on: assert property (o_fast_osc_keep_on |-> i_sleep)
      else $error("keep on outside sleep");
   a_keep_source: assert property
      ((i_psel && i_paddr == `NCO_ADDR_CLOCK && o_fast_osc_keep_on)
      |-> o_prdata[3:0] == 4'h1)
      else $error("keep on with other source");
   a_out_status: assert property
      ((i_psel && i_paddr == `NCO_ADDR_CONTROL)
      |-> o_prdata[5] == o_oscillator_output)
      else $error("status bit differs from output");
   a_irq_cause: assert property
      ($rose(o_overflow_irq) |->
      $past(o_raw_carry_out) || $past(wr) || $past(wr, 2))
      else $error("irq rose without cause");
   a_irq_hold: assert property (o_overflow_irq && !wr |=> o_overflow_irq)
      else $error("irq dropped without software");
   c_carry: cover property (o_raw_carry_out);
   c_irq: cover property ($rose(o_overflow_irq));
   c_keep: cover property (o_fast_osc_keep_on);
endmodule

bind nco_core nco_props u_props (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
   .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
   .i_paddr(i_paddr), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .o_prdata(o_prdata), .i_sleep(i_sleep),
   .o_oscillator_output(o_oscillator_output),
   .o_overflow_irq(o_overflow_irq), .o_fast_osc_keep_on(o_fast_osc_keep_on),
   .o_raw_carry_out(o_raw_carry_out));

// >>> bench/test_numeric_oscillator.sv
// self-checking bench for the numeric oscillator
`timescale 1ns/1ps
`include "nco_defs.vh"
module test_numeric_oscillator;
   reg i_clock, i_sys_rst, psel, pen, pwr, sleep, o1;
   reg [11:0] addr;
   reg [31:0] wdat, rd, r1;
   reg [15:0] src;
   reg [3:0] div;
   wire rdy, err, outp, irq, keep, cy;
   wire [31:0] prd;
   integer n_mismatch, tests_run, k, c;
   nco_core dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_psel(psel),
      .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdat),
      .o_pready(rdy), .o_pslverr(err), .o_prdata(prd),
      .i_clock_sources(src), .i_sleep(sleep),
      .o_oscillator_output(outp), .o_overflow_irq(irq),
      .o_fast_osc_keep_on(keep), .o_raw_carry_out(cy));
   // system clock, 100 ns
   initial begin
      i_clock = 0;
      forever #50 i_clock = ~i_clock;
   end
   // every source rises once per 8 system clocks
   always @(posedge i_clock) begin
      div <= div + 4'h1;
      src <= {16{div[2]}};
   end
   task chk(input [8*12:1] nm, input [31:0] e, input [31:0] g);
      begin
         tests_run = tests_run + 1;
         if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("ERROR %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   // one apb transfer; read data taken at the ready edge
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge i_clock);
         {psel, pen, pwr, addr, wdat} <= {2'b10, w, a, d};
         @(posedge i_clock);
         pen <= 1'b1;
         @(posedge i_clock);
         while (rdy !== 1'b1) @(posedge i_clock);
         rd = prd;
         {psel, pen} <= 2'b00;
      end
   endtask
   task wr(input [11:0] a, input [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rdr(input [11:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   // clocks up to the next carry, capped at 300
   task wcy;
      begin
         c = 0;
         do begin
            @(negedge i_clock);
            c = c + 1;
         end while (cy !== 1'b1 && c < 300);
      end
   endtask
   // length of the second full high phase of the output
   task whi;
      repeat (2) begin
         while (outp !== 1'b0) @(negedge i_clock);
         while (outp !== 1'b1) @(negedge i_clock);
         c = 0;
         while (outp === 1'b1) begin
            c = c + 1;
            @(negedge i_clock);
         end
      end
   endtask
   // index 9 is past the map and must read zero
   task t_reset;
      for (k = 0; k < 10; k = k + 1) begin
         rdr(12'(k * 4));
         chk("reset_read", 32'h0, rd);
         chk("pslverr", 32'h0, err);
      end
   endtask
   task t_regs;
      begin
         wr(`NCO_ADDR_ACC_UPPER, 32'h1A);
         rdr(`NCO_ADDR_ACC_UPPER);
         chk("acc_upper", 32'hA, rd);
         wr(`NCO_ADDR_INC_HIGH, 32'h5C);
         rdr(`NCO_ADDR_INC_HIGH);
         chk("inc_high", 32'h5C, rd);
         wr(`NCO_ADDR_ACC_UPPER, 32'h0);
         wr(`NCO_ADDR_INC_HIGH, 32'h0);
      end
   endtask
   // increment 0x40000 overflows every 4 ticks of 8 clocks
   task t_fixed;
      begin
         wr(`NCO_ADDR_INC_UPPER, 32'h4);
         wr(`NCO_ADDR_CONTROL, 32'h80);
         wcy;
         wcy;
         chk("fdc_period", 32, c);
         repeat (2) @(negedge i_clock);
         o1 = outp;
         wcy;
         repeat (2) @(negedge i_clock);
         chk("fdc_toggle", !o1, outp);
         wr(`NCO_ADDR_INC_UPPER, 32'h8);
         wcy;
         wcy;
         chk("no_early_load", 32, c);
         wr(`NCO_ADDR_INC_LOW, 32'h0);
         repeat (3) wcy;
         wcy;
         chk("loaded_period", 16, c);
         wr(`NCO_ADDR_CONTROL, 32'h0);
         rdr(`NCO_ADDR_ACC_UPPER);
         r1 = rd;
         wcy;
         chk("no_carry_off", 300, c);
         rdr(`NCO_ADDR_ACC_UPPER);
         chk("acc_holds", r1, rd);
      end
   endtask
   task t_pulse;
      begin
         wr(`NCO_ADDR_INC_UPPER, 32'h4);
         wr(`NCO_ADDR_CONTROL, 32'h81);
         whi;
         chk("pulse_w1", 8, c);
         wr(`NCO_ADDR_CLOCK, 32'h20);
         whi;
         chk("pulse_w2", 16, c);
         wr(`NCO_ADDR_CLOCK, 32'h0);
         wr(`NCO_ADDR_CONTROL, 32'h91);
         whi;
         chk("pulse_inv", 24, c);
         wr(`NCO_ADDR_CONTROL, 32'h81);
         wr(`NCO_ADDR_CLOCK, 32'hE0);
         repeat (40) @(negedge i_clock);
         c = 0;
         repeat (200) @(negedge i_clock) c = c + (outp !== 1'b1);
         chk("no_toggle", 0, c);
      end
   endtask
   task t_irq;
      begin
         wr(`NCO_ADDR_CLOCK, 32'h0);
         wr(`NCO_ADDR_CONTROL, 32'h80);
         wr(`NCO_ADDR_IRQ, 32'h0E);
         wcy;
         @(negedge i_clock);
         chk("irq_set", 1, irq);
         wr(`NCO_ADDR_IRQ, 32'h06);
         wcy;
         @(negedge i_clock);
         chk("irq_gated", 0, irq);
         rdr(`NCO_ADDR_IRQ);
         chk("flag_gated", 32'h7, rd);
         wr(`NCO_ADDR_INC_UPPER, 32'h0);
         wr(`NCO_ADDR_INC_LOW, 32'h0);
         repeat (30) @(negedge i_clock);
         wr(`NCO_ADDR_IRQ, 32'h0E);
         rdr(`NCO_ADDR_IRQ);
         chk("flag_clear", 32'hE, rd);
         wr(`NCO_ADDR_CONTROL, 32'h90);
         repeat (50) @(negedge i_clock);
         chk("irq_invert", 1, irq);
      end
   endtask
   task t_sleep;
      begin
         wr(`NCO_ADDR_CLOCK, 32'h1);
         @(posedge i_clock) sleep <= 1'b1;
         @(negedge i_clock);
         chk("keep_on", 1, keep);
         wr(`NCO_ADDR_CLOCK, 32'h0);
         @(negedge i_clock);
         chk("keep_off", 0, keep);
      end
   endtask
   task finish_test;
      begin
         $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
         if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
         else $display("TEST FAILED");
         $finish;
      end
   endtask
   // main sequence
   initial begin
      {psel, pen, pwr, addr, wdat, sleep, div, src} = 0;
      n_mismatch = 0;
      tests_run = 0;
      i_sys_rst = 1'b1;
      repeat (16) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      t_reset;
      t_regs;
      t_fixed;
      t_pulse;
      t_irq;
      t_sleep;
      finish_test;
   end
   // watchdog, well beyond the expected run of under two thousand clocks
   initial begin
      repeat (20000) @(posedge i_clock);
      n_mismatch = n_mismatch + 1;
      finish_test;
   end
endmodule
